// ### hw/eight_bit_reload_timer.sv
// Contract
// [R1] mode register resets to 0x78
// [R2] mode bits 6..3 read one, ignore writes
// [R3] mode bit 7 picks interval or reload
// [R4] codes 0..6 pick seven prescaler taps
// [R5] code 7 counts chosen edge of pin
// [R6] software enables pin function before code 7
// [R7] 8-bit up counter, readable, not writable
// [R8] step from 0xff sets overflow flag
// [R9] interrupt only when enable and flag set
// [R10] interval overflow returns counter to zero
// [R11] reload overflow loads reload register
// [R12] reload write also loads the counter
// [R13] shared address: read counter, write reload
// [R14] counter and reload reset to zero
// [R15] counts in interval mode from reset
// [R16] halted in low power, mode retained
// [R17] single-cycle enable, event pin synchronised
// [R18] reload write beats overflow same cycle
`timescale 1ns/10ps
`default_nettype none
module eight_bit_reload_timer (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // event input and power state
    input wire logic event_input_pin,
    input wire logic counter_halt,
    // interrupt
    output logic irq
);

    timer_b_pkg::timer_state_s r;
    timer_b_pkg::timer_state_s n;

    logic [timer_b_pkg::TAP_COUNT-1:0] tap_tick;
    logic accept;
    logic ev_edge;
    logic count_en;
    logic overflow;
    logic reload_write;
    logic flag_clear;

    prescaler_taps u_taps (
        .hclk(hclk),
        .hresetn(hresetn),
        .tap_tick(tap_tick)
    );

    // true when the write data phase in flight targets the given register
    function automatic logic wr_hit(input timer_b_pkg::timer_state_s s,
                                    input logic [15:0] index);
        return s.ph_valid && s.ph_write && (s.ph_index == index);
    endfunction

    // mode register as software sees it
    function automatic logic [7:0] mode_value(input timer_b_pkg::timer_state_s s);
        return {s.reload_mode, timer_b_pkg::MODE_RESERVED_ONES, s.clk_sel}; // [R2]
    endfunction

    // one-bit field placed at its position in a word
    function automatic logic [31:0] bit_word(input logic b, input int pos);
        logic [31:0] w;
        w = timer_b_pkg::RDATA_ZERO;
        w[pos] = b;
        return w;
    endfunction

    // read mux, sampled in the address phase so hrdata is a flop
    function automatic logic [31:0] read_value(input timer_b_pkg::timer_state_s s,
                                               input logic [15:0] index);
        logic [31:0] v;
        v = timer_b_pkg::RDATA_ZERO;
        case (index)
            timer_b_pkg::MODE_INDEX: begin
                v[7:0] = mode_value(s);
            end
            timer_b_pkg::COUNT_INDEX: begin
                // reload register is write only; reads see the counter
                v[7:0] = s.count; // [R13] [R7]
            end
            timer_b_pkg::IRQ_STATUS_INDEX: begin
                v = bit_word(s.ovf_flag, timer_b_pkg::OVF_FLAG_BIT);
            end
            timer_b_pkg::IRQ_MASK_INDEX: begin
                v = bit_word(s.ovf_irq_en, timer_b_pkg::OVF_IRQ_EN_BIT);
            end
            timer_b_pkg::EDGE_SELECT_INDEX: begin
                v = bit_word(s.edge_rise, timer_b_pkg::EDGE_RISE_BIT);
            end
            timer_b_pkg::PORT_MODE_INDEX: begin
                v = bit_word(s.pin_fn, timer_b_pkg::PIN_FN_BIT);
            end
            default: begin
                v = timer_b_pkg::RDATA_ZERO;
            end
        endcase
        return v;
    endfunction

    // zero wait states: every transfer completes in its first data cycle
    assign hreadyout = 1'b1;
    assign hresp = timer_b_pkg::HRESP_OKAY;
    assign hrdata = r.rdata;
    assign irq = r.irq;

    always_comb begin
        n = r;

        // event pin: two-flop synchroniser, then an edge detector on the second
        n.ev_meta = event_input_pin; // [R17]
        n.ev_sync = r.ev_meta; // [R17]
        n.ev_prev = r.ev_sync;
        if (r.edge_rise) begin
            ev_edge = r.ev_sync && !r.ev_prev; // [R5]
        end else begin
            ev_edge = !r.ev_sync && r.ev_prev; // [R5]
        end

        // count enable is one system-clock cycle wide whatever the source
        if (r.clk_sel == timer_b_pkg::CLK_SEL_EVENT) begin
            // pin events are only seen once the pin has its event function
            count_en = ev_edge && r.pin_fn; // [R5] [R6]
        end else begin
            count_en = tap_tick[r.clk_sel]; // [R4] [R17]
        end
        // low-power states stop counting; the mode fields are left as they are
        count_en = count_en && !counter_halt; // [R16]

        overflow = count_en && (r.count == timer_b_pkg::COUNT_MAX); // [R8]

        if (count_en) begin
            if (overflow) begin
                if (r.reload_mode) begin
                    n.count = r.reload; // [R3] [R11]
                end else begin
                    n.count = timer_b_pkg::COUNT_ZERO; // [R3] [R10]
                end
            end else begin
                n.count = r.count + timer_b_pkg::COUNT_STEP; // [R7] [R15]
            end
        end

        // data phase writes
        reload_write = wr_hit(r, timer_b_pkg::COUNT_INDEX);
        flag_clear = 1'b0;

        if (wr_hit(r, timer_b_pkg::MODE_INDEX)) begin
            n.reload_mode = hwdata[timer_b_pkg::RELOAD_MODE_BIT]; // [R3]
            n.clk_sel = hwdata[timer_b_pkg::CLK_SEL_HI:timer_b_pkg::CLK_SEL_LO]; // [R4]
        end

        if (reload_write) begin
            // written value beats an overflow reload in the same cycle
            n.reload = hwdata[7:0]; // [R13]
            n.count = hwdata[7:0]; // [R12] [R18]
        end

        if (wr_hit(r, timer_b_pkg::IRQ_STATUS_INDEX)) begin
            flag_clear = hwdata[timer_b_pkg::OVF_FLAG_BIT];
        end

        if (wr_hit(r, timer_b_pkg::IRQ_MASK_INDEX)) begin
            n.ovf_irq_en = hwdata[timer_b_pkg::OVF_IRQ_EN_BIT];
        end

        if (wr_hit(r, timer_b_pkg::EDGE_SELECT_INDEX)) begin
            n.edge_rise = hwdata[timer_b_pkg::EDGE_RISE_BIT];
        end

        if (wr_hit(r, timer_b_pkg::PORT_MODE_INDEX)) begin
            n.pin_fn = hwdata[timer_b_pkg::PIN_FN_BIT];
        end

        // a new overflow survives a write-one-to-clear in the same cycle
        n.ovf_flag = overflow || (r.ovf_flag && !flag_clear); // [R8]

        // registered so the pin has no path from the bus
        n.irq = n.ovf_flag && n.ovf_irq_en; // [R9]

        // address phase
        accept = hsel && hready && htrans[1];
        n.ph_valid = accept;
        n.ph_write = hwrite;
        n.ph_index = timer_b_pkg::INDEX_NONE;
        if (accept && (haddr[timer_b_pkg::ADDR_TOP_HI:timer_b_pkg::ADDR_TOP_LO]
                == timer_b_pkg::ADDR_TOP_ZERO)) begin
            n.ph_index = haddr[timer_b_pkg::ADDR_INDEX_HI:timer_b_pkg::ADDR_INDEX_LO];
        end
        n.rdata = timer_b_pkg::RDATA_ZERO;
        if (accept && !hwrite) begin
            n.rdata = read_value(r, n.ph_index);
        end
    end

    // reset constant sets mode 0x78, counter and reload 0x00
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= timer_b_pkg::STATE_RESET; // [R1] [R14] [R15]
        end else begin
            r <= n;
        end
    end

endmodule
`default_nettype wire

// ### hw/timer_b_pkg.sv
`default_nettype none
package timer_b_pkg;

    // register indices; the byte address on the bus is four times the index
    localparam logic [15:0] MODE_INDEX = 16'hffb2;
    localparam logic [15:0] COUNT_INDEX = 16'hffb3;
    localparam logic [15:0] IRQ_STATUS_INDEX = 16'hffb8;
    localparam logic [15:0] IRQ_MASK_INDEX = 16'hffb9;
    localparam logic [15:0] EDGE_SELECT_INDEX = 16'hffba;
    localparam logic [15:0] PORT_MODE_INDEX = 16'hffbb;

    // byte address split
    localparam int ADDR_INDEX_LO = 2;
    localparam int ADDR_INDEX_HI = 17;
    localparam int ADDR_TOP_LO = 18;
    localparam int ADDR_TOP_HI = 31;
    localparam logic [13:0] ADDR_TOP_ZERO = 14'h0000;

    // mode register layout
    localparam int RELOAD_MODE_BIT = 7;
    localparam int CLK_SEL_HI = 2;
    localparam int CLK_SEL_LO = 0;
    localparam logic [3:0] MODE_RESERVED_ONES = 4'hf;
    localparam logic [7:0] MODE_RESET = 8'h78;

    // one-bit fields of the added registers
    localparam int OVF_FLAG_BIT = 0;
    localparam int OVF_IRQ_EN_BIT = 0;
    localparam int EDGE_RISE_BIT = 0;
    localparam int PIN_FN_BIT = 0;

    // counter values
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic [7:0] COUNT_ZERO = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_STEP = 8'h01;

    // clock source codes
    localparam logic [2:0] CLK_SEL_RESET = 3'h0;
    localparam logic [2:0] CLK_SEL_EVENT = 3'h7;
    localparam int TAP_COUNT = 7;

    // log2 of the divide ratio of each prescaler tap, codes 0 to 6
    localparam int PRESCALE_WIDTH = 13;
    localparam int TAP_LOG2_0 = 13;
    localparam int TAP_LOG2_1 = 11;
    localparam int TAP_LOG2_2 = 9;
    localparam int TAP_LOG2_3 = 8;
    localparam int TAP_LOG2_4 = 6;
    localparam int TAP_LOG2_5 = 4;
    localparam int TAP_LOG2_6 = 2;

    // ahb-lite
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic [31:0] RDATA_ZERO = 32'h00000000;
    localparam logic [15:0] INDEX_NONE = 16'h0000;

    typedef struct packed {
        logic reload_mode;
        logic [2:0] clk_sel;
        logic [7:0] count;
        logic [7:0] reload;
        logic ovf_flag;
        logic ovf_irq_en;
        logic edge_rise;
        logic pin_fn;
        logic ev_meta;
        logic ev_sync;
        logic ev_prev;
        logic ph_valid;
        logic ph_write;
        logic [15:0] ph_index;
        logic [31:0] rdata;
        logic irq;
    } timer_state_s;

    localparam timer_state_s STATE_RESET = '{
        reload_mode: MODE_RESET[RELOAD_MODE_BIT],
        clk_sel: MODE_RESET[CLK_SEL_HI:CLK_SEL_LO],
        count: COUNT_RESET,
        reload: RELOAD_RESET,
        ovf_flag: 1'b0,
        ovf_irq_en: 1'b0,
        edge_rise: 1'b0,
        pin_fn: 1'b0,
        ev_meta: 1'b0,
        ev_sync: 1'b0,
        ev_prev: 1'b0,
        ph_valid: 1'b0,
        ph_write: 1'b0,
        ph_index: INDEX_NONE,
        rdata: RDATA_ZERO,
        irq: 1'b0
    };

endpackage
`default_nettype wire

// ### hw/prescaler_taps.sv
`timescale 1ns/10ps
`default_nettype none
module prescaler_taps (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // one-cycle pulse per tap, index is the clock source code
    output logic [timer_b_pkg::TAP_COUNT-1:0] tap_tick
);

    logic [timer_b_pkg::PRESCALE_WIDTH-1:0] div;
    logic [timer_b_pkg::TAP_COUNT-1:0] next_tap_tick;

    // a tap fires once per wrap of its low bits
    function automatic logic wrap(input logic [timer_b_pkg::PRESCALE_WIDTH-1:0] d,
                                  input int log2);
        logic all_ones;
        all_ones = 1'b1;
        for (int i = 0; i < timer_b_pkg::PRESCALE_WIDTH; i++) begin
            if (i < log2) begin
                all_ones = all_ones & d[i];
            end
        end
        return all_ones;
    endfunction

    always_comb begin
        next_tap_tick[0] = wrap(div, timer_b_pkg::TAP_LOG2_0);
        next_tap_tick[1] = wrap(div, timer_b_pkg::TAP_LOG2_1);
        next_tap_tick[2] = wrap(div, timer_b_pkg::TAP_LOG2_2);
        next_tap_tick[3] = wrap(div, timer_b_pkg::TAP_LOG2_3);
        next_tap_tick[4] = wrap(div, timer_b_pkg::TAP_LOG2_4);
        next_tap_tick[5] = wrap(div, timer_b_pkg::TAP_LOG2_5);
        next_tap_tick[6] = wrap(div, timer_b_pkg::TAP_LOG2_6);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div <= '0;
            tap_tick <= '0;
        end else begin
            div <= div + 1'b1;
            tap_tick <= next_tap_tick;
        end
    end

endmodule
`default_nettype wire

// ### tb/timer_b_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module timer_b_checker (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // interrupt
    input wire logic irq
);
    logic take, dph_rd, dph_wr, en, fresh, fresh_q, clr;
    logic [15:0] dph_idx;
    logic [7:0] mode_exp, wr_val;
    assign take = hsel && hready && htrans[1] && (haddr[31:18] == 14'h0000);
    assign clr = dph_wr && (dph_idx == timer_b_pkg::IRQ_STATUS_INDEX
        || dph_idx == timer_b_pkg::IRQ_MASK_INDEX);
    // shadow of what software wrote, tracked from data phases only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {dph_rd, dph_wr, en, fresh, fresh_q, dph_idx, wr_val} <= '0;
            mode_exp <= 8'h78;
        end else begin
            dph_rd <= take && !hwrite;
            dph_wr <= take && hwrite;
            dph_idx <= haddr[17:2];
            fresh <= dph_wr && dph_idx == timer_b_pkg::COUNT_INDEX;
            fresh_q <= fresh && take && !hwrite && haddr[17:2] == timer_b_pkg::COUNT_INDEX;
            if (dph_wr && dph_idx == timer_b_pkg::MODE_INDEX)
                mode_exp <= {hwdata[7], 4'hf, hwdata[2:0]};
            if (dph_wr && dph_idx == timer_b_pkg::IRQ_MASK_INDEX)
                en <= hwdata[0];
            if (dph_wr && dph_idx == timer_b_pkg::COUNT_INDEX)
                wr_val <= hwdata[7:0];
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    reserved_ones_a: assert property (dph_rd && dph_idx == timer_b_pkg::MODE_INDEX
        |-> hrdata[6:3] == 4'hf) else $error("reserved mode bits not one");
    mode_value_a: assert property (dph_rd && dph_idx == timer_b_pkg::MODE_INDEX
        |-> hrdata[7:0] == mode_exp) else $error("mode readback wrong");
    upper_zero_a: assert property (hrdata[31:8] == 24'h000000)
        else $error("read data above bit 7");
    idle_data_a: assert property (!dph_rd |-> hrdata == 32'h00000000)
        else $error("read data outside data phase");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    irq_mask_a: assert property (!en |-> !irq)
        else $error("interrupt while disabled");
    irq_sticky_a: assert property ($fell(irq) |-> $past(clr))
        else $error("interrupt dropped without clear");
    reload_load_a: assert property (fresh_q
        |-> hrdata[7:0] == wr_val || hrdata[7:0] == wr_val + 8'h01)
        else $error("counter not loaded by reload write");
endmodule
bind eight_bit_reload_timer timer_b_checker chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));
`default_nettype wire

// ### tb/eight_bit_reload_timer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module eight_bit_reload_timer_tb;
    logic hclk, hresetn, hsel, hwrite, hresp, event_input_pin, counter_halt, irq, hreadyout;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] v;
    wire logic hready = hreadyout;
    int failures, cmp_count, cycles;
    localparam logic [15:0] MD = timer_b_pkg::MODE_INDEX;
    localparam logic [15:0] CN = timer_b_pkg::COUNT_INDEX;
    localparam logic [15:0] ST = timer_b_pkg::IRQ_STATUS_INDEX;
    localparam logic [15:0] MK = timer_b_pkg::IRQ_MASK_INDEX;
    eight_bit_reload_timer uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .event_input_pin(event_input_pin), .counter_halt(counter_halt), .irq(irq));
    task automatic close_out;
        if (failures == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check_eq(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
        cmp_count++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // one single transfer; read data taken at the data phase's ready edge
    task automatic bus(input logic [15:0] idx, input logic wr, input logic [7:0] wd);
        hsel <= 1'b1;
        haddr <= {14'h0000, idx, 2'h0};
        htrans <= timer_b_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= timer_b_pkg::HTRANS_IDLE;
        hwdata <= {24'h000000, wd};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        v = hrdata[7:0];
    endtask
    task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp);
        bus(idx, 1'b0, 8'h00);
        check_eq(v, exp);
    endtask
    task automatic pulse;
        event_input_pin <= 1'b1;
        cyc(6);
        event_input_pin <= 1'b0;
        cyc(6);
    endtask
    task automatic t_reset;
        rd_chk(MD, 8'h78);
        rd_chk(CN, 8'h00);
        rd_chk(16'h0100, 8'h00);
        cyc(8300);
        rd_chk(CN, 8'h01);
        bus(MD, 1'b1, 8'h07);
        rd_chk(MD, 8'h7f);
        bus(MD, 1'b1, 8'h80);
        rd_chk(MD, 8'hf8);
    endtask
    task automatic t_taps;
        int lg[7] = '{13, 11, 9, 8, 6, 4, 2};
        for (int k = 0; k < 7; k++) begin
            bus(MD, 1'b1, {5'h0f, k[2:0]});
            bus(CN, 1'b1, 8'h00);
            cyc(4 << lg[k]);
            bus(CN, 1'b0, 8'h00);
            check_rng(v, 8'h03, 8'h05);
        end
    endtask
    task automatic t_event;
        bus(timer_b_pkg::PORT_MODE_INDEX, 1'b1, 8'h01);
        bus(timer_b_pkg::EDGE_SELECT_INDEX, 1'b1, 8'h01);
        bus(MD, 1'b1, 8'h07);
        bus(CN, 1'b1, 8'h00);
        repeat (3) pulse;
        rd_chk(CN, 8'h03);
        bus(timer_b_pkg::EDGE_SELECT_INDEX, 1'b1, 8'h00);
        bus(CN, 1'b1, 8'h00);
        event_input_pin <= 1'b1;
        cyc(8);
        rd_chk(CN, 8'h00);
        event_input_pin <= 1'b0;
        cyc(8);
        rd_chk(CN, 8'h01);
        counter_halt <= 1'b1;
        pulse;
        rd_chk(CN, 8'h01);
        rd_chk(MD, 8'h7f);
        counter_halt <= 1'b0;
    endtask
    task automatic t_ovf;
        bus(MK, 1'b1, 8'h01);
        bus(CN, 1'b1, 8'hfe);
        repeat (2) pulse;
        rd_chk(CN, 8'h00);
        rd_chk(ST, 8'h01);
        check_eq({7'h00, irq}, 8'h01);
        bus(ST, 1'b1, 8'h01);
        rd_chk(ST, 8'h00);
        bus(MK, 1'b1, 8'h00);
        bus(CN, 1'b1, 8'hff);
        pulse;
        check_eq({7'h00, irq}, 8'h00);
        bus(MK, 1'b1, 8'h01);
        cyc(1);
        check_eq({7'h00, irq}, 8'h01);
        bus(ST, 1'b1, 8'h01);
    endtask
    task automatic t_reload;
        bus(MD, 1'b1, 8'h87);
        bus(CN, 1'b1, 8'h80);
        rd_chk(CN, 8'h80);
        bus(CN, 1'b1, 8'hfd);
        repeat (3) pulse;
        rd_chk(CN, 8'hfd);
        pulse;
        rd_chk(CN, 8'hfe);
        // falling edge reaches the counter three edges on, with the write
        bus(ST, 1'b1, 8'h01);
        bus(CN, 1'b1, 8'hff);
        event_input_pin <= 1'b1;
        cyc(6);
        event_input_pin <= 1'b0;
        cyc(1);
        bus(CN, 1'b1, 8'h42);
        rd_chk(CN, 8'h42);
        rd_chk(ST, 8'h01);
    endtask
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 80000) begin
            failures++;
            close_out();
        end
    end
    initial begin
        {hresetn, hsel, hwrite, event_input_pin, counter_halt} = 5'h00;
        {haddr, hwdata} = 64'h0;
        htrans = timer_b_pkg::HTRANS_IDLE;
        hsize = 3'h2;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_taps();
        t_event();
        t_ovf();
        t_reload();
        close_out();
    end
endmodule
`default_nettype wire
